// ### core/controller_sequence_word_mapper.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 213 replies count three, both limits
// - bcd write value, top digit A or F refused
// - 214 replies count, current, status word
// - 215 status byte in word one low
// - 215 word two holds three type digits
// - general write stores no receive words
// - general read replies count two, value
// - completion code stripped from read value
module controller_sequence_word_mapper
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // host command
    input wire logic i_start,
    input wire seq_map_pkg::send_blk_t i_send,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    // receive block readback
    input wire logic [1:0] i_rx_addr,
    output logic [15:0] o_rx_data,
    output logic [15:0] o_rx_words,
    // controller link
    output logic o_link_req,
    output seq_map_pkg::link_req_t o_link,
    input wire logic i_link_ack,
    input wire logic i_reply_valid,
    input wire seq_map_pkg::reply_t i_reply
);
    import seq_map_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEND = 3'b001,
        ST_WAIT = 3'b010,
        ST_W0 = 3'b011,
        ST_W1 = 3'b100,
        ST_W2 = 3'b101,
        ST_DONE = 3'b110
    } state_t;

    // ==========================================================
    // helper functions
    // ==========================================================
    function automatic logic is_bcd2(input logic [7:0] b);
        is_bcd2 = (b[7:4] <= DIGIT_MAX) && (b[3:0] <= DIGIT_MAX);
    endfunction

    // top digit may carry the -1 or minus marker
    function automatic logic is_bcd4(input logic [15:0] w, input logic signs);
        logic top_ok;
        top_ok = (w[15:12] <= DIGIT_MAX)
            || (signs && (w[15:12] == NEG_ONE_DIGIT || w[15:12] == MINUS_DIGIT));
        is_bcd4 = top_ok && is_bcd2(w[11:4]) && (w[3:0] <= DIGIT_MAX);
    endfunction

    function automatic logic hdr_ok(input logic [15:0] h, input logic wr);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 7; k++)
        begin
            if (h == (wr ? HDR_W[k] : HDR_R[k]))
            begin
                hit = 1'b1;
            end
        end
        hdr_ok = hit;
    endfunction

    // ==========================================================
    // send block validation
    // ==========================================================
    logic send_ok;
    logic [7:0] unit_b;
    logic [7:0] dcode_b;
    always_comb
    begin
        unit_b = i_send.unit_word[7:0];
        dcode_b = i_send.dcode_word[7:0];
        send_ok = is_bcd2(unit_b) && (unit_b <= UNIT_MAX);
        case (i_send.seq)
            SEQ_SP_LIMIT, SEQ_HEATER, SEQ_INIT_STAT:
                send_ok = send_ok && (i_send.count == CNT_TWO);
            SEQ_GP_WRITE:
                send_ok = send_ok && (i_send.count == CNT_FIVE)
                    && hdr_ok(i_send.header, 1'b1) && is_bcd2(dcode_b)
                    && dcode_b >= DCODE_MIN && dcode_b <= DCODE_MAX
                    && is_bcd4(i_send.wdata, 1'b0);
            SEQ_GP_READ:
                send_ok = send_ok && (i_send.count == CNT_FOUR)
                    && hdr_ok(i_send.header, 1'b0) && is_bcd2(dcode_b)
                    && dcode_b >= DCODE_MIN && dcode_b <= DCODE_MAX;
            default:
                send_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // sequencer state
    // ==========================================================
    state_t state_ff, nxt_state;
    link_req_t req_ff, nxt_req;
    reply_t rep_ff, nxt_rep;
    logic err_ff, nxt_err;
    logic [15:0] words_ff, nxt_words;
    logic we;
    logic [1:0] waddr;
    logic [15:0] wdata;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_rep = rep_ff;
        nxt_err = err_ff;
        nxt_words = words_ff;
        case (state_ff)
            ST_IDLE:
                if (i_start && !send_ok)
                begin
                    nxt_err = 1'b1;
                    nxt_state = ST_DONE;
                end
                else if (i_start)
                begin
                    nxt_err = 1'b0;
                    nxt_req = '{i_send.seq, unit_b, i_send.header, dcode_b, i_send.wdata};
                    nxt_state = ST_SEND;
                end
            ST_SEND:
                nxt_state = i_link_ack ? ST_WAIT : ST_SEND;
            ST_WAIT:
                if (i_reply_valid)
                begin
                    nxt_rep = i_reply;
                    // write completes with no receive words
                    if (req_ff.seq == SEQ_GP_WRITE)
                    begin
                        nxt_words = 16'h0000;
                        nxt_state = ST_DONE;
                    end
                    else
                    begin
                        nxt_state = ST_W0;
                    end
                end
            ST_W0:
            begin
                nxt_words = (req_ff.seq == SEQ_GP_READ) ? CNT_TWO : CNT_THREE;
                nxt_state = ST_W1;
            end
            ST_W1:
                nxt_state = (req_ff.seq == SEQ_GP_READ) ? ST_DONE : ST_W2;
            ST_W2:
                nxt_state = ST_DONE;
            ST_DONE:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            rep_ff <= '0;
            err_ff <= 1'b0;
            words_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            rep_ff <= nxt_rep;
            err_ff <= nxt_err;
            words_ff <= nxt_words;
        end
    end

    // ==========================================================
    // receive word packing
    // ==========================================================
    always_comb
    begin
        we = 1'b0;
        waddr = RX_W0;
        wdata = 16'h0000;
        case (state_ff)
            ST_W0:
            begin
                we = 1'b1;
                wdata = (req_ff.seq == SEQ_GP_READ) ? CNT_TWO : CNT_THREE;
            end
            ST_W1:
            begin
                we = 1'b1;
                waddr = RX_W1;
                // status byte, high byte left zero
                wdata = (req_ff.seq == SEQ_INIT_STAT) ? {8'h00, rep_ff.value[7:0]}
                    : rep_ff.value;
            end
            ST_W2:
            begin
                we = 1'b1;
                waddr = RX_W2;
                wdata = (req_ff.seq == SEQ_INIT_STAT) ? {4'h0, rep_ff.aux[11:0]}
                    : rep_ff.aux;
            end
            default:
                we = 1'b0;
        endcase
    end

    rx_word_mem #(.DEPTH(RX_DEPTH), .AW(2)) u_mem (
        .i_clk(i_clk),
        .i_we(we),
        .i_waddr(waddr),
        .i_wdata(wdata),
        .i_raddr(i_rx_addr),
        .o_rdata(o_rx_data)
    );

    // handshake outputs straight from state, error from its own flag
    assign o_busy = (state_ff != ST_IDLE);
    assign o_done = (state_ff == ST_DONE);
    assign o_error = err_ff;
    assign o_link_req = (state_ff == ST_SEND);
    assign o_link = req_ff;
    assign o_rx_words = words_ff;

    // ==========================================================
    // checks
    // ==========================================================
    AST_NO_SEND_ON_ERR: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_ff == ST_IDLE && i_start && !send_ok) |=> (o_done && o_error && !o_link_req))
        else $error("bad send block reached the link");
    AST_WRITE_NO_RX: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_ff == ST_WAIT && i_reply_valid && req_ff.seq == SEQ_GP_WRITE)
        |=> (o_done && !we && o_rx_words == 16'h0000))
        else $error("general write stored receive words");
    AST_READ_COUNT: assert property (@(posedge i_clk) disable iff (i_srst)
        (we && waddr == RX_W0 && req_ff.seq == SEQ_GP_READ) |-> wdata == 16'h0002)
        else $error("general read count wrong");
    AST_STAT_COUNT: assert property (@(posedge i_clk) disable iff (i_srst)
        (we && waddr == RX_W0 && req_ff.seq != SEQ_GP_READ) |-> wdata == 16'h0003)
        else $error("status read count wrong");
    AST_INIT_HIGH: assert property (@(posedge i_clk) disable iff (i_srst)
        (we && waddr == RX_W1 && req_ff.seq == SEQ_INIT_STAT)
        |-> wdata == {8'h00, $past(i_reply.value[7:0], 2)})
        else $error("initial status word not the reply status byte");
    AST_TYPES_TOP: assert property (@(posedge i_clk) disable iff (i_srst)
        (we && waddr == RX_W2 && req_ff.seq == SEQ_INIT_STAT)
        |-> wdata == {4'h0, $past(i_reply.aux[11:0], 3)})
        else $error("type word not the three reply digits");
    AST_VALUE_PASS: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_ff == ST_WAIT && i_reply_valid && req_ff.seq == SEQ_GP_READ)
        |-> ##2 (we && waddr == RX_W1 && wdata == $past(i_reply.value, 2)))
        else $error("read value not the reply value");
    AST_LINK_UNIT: assert property (@(posedge i_clk) disable iff (i_srst)
        o_link_req |-> (o_link.unit <= 8'h31 && o_link.unit[3:0] <= 4'h9))
        else $error("unit number out of range on link");
    AST_DCODE: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_link_req && o_link.seq >= 9'd216) |-> (o_link.dcode inside {8'h01, 8'h02}))
        else $error("data code out of range on link");
    AST_STATUS_SEQ: assert property (@(posedge i_clk) disable iff (i_srst)
        (we && waddr == RX_W2) |-> ##1 (state_ff == ST_DONE) ##1 (state_ff == ST_IDLE))
        else $error("word two not last write");
endmodule
`default_nettype wire

// ### core/rx_word_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rx_word_mem #(
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // clock
    input wire logic i_clk,
    // write side
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [15:0] i_wdata,
    // read side
    input wire logic [AW-1:0] i_raddr,
    output logic [15:0] o_rdata
);
    logic [15:0] mem_ff [DEPTH];
    logic [15:0] rdata_ff;

    // ==========================================================
    // write and registered read
    // ==========================================================
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem_ff[i_waddr] <= i_wdata;
        end
        rdata_ff <= mem_ff[i_raddr];
    end

    assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// ### core/seq_map_pkg.sv
`default_nettype none
package seq_map_pkg;

    // ==========================================================
    // sequence numbers handled here
    // ==========================================================
    localparam logic [8:0] SEQ_SP_LIMIT = 9'd213;
    localparam logic [8:0] SEQ_HEATER = 9'd214;
    localparam logic [8:0] SEQ_INIT_STAT = 9'd215;
    localparam logic [8:0] SEQ_GP_WRITE = 9'd216;
    localparam logic [8:0] SEQ_GP_READ = 9'd217;

    // ==========================================================
    // word counts in four bcd digits, then field limits and digit codes
    // ==========================================================
    localparam logic [15:0] CNT_TWO = 16'h0002;
    localparam logic [15:0] CNT_THREE = 16'h0003;
    localparam logic [15:0] CNT_FOUR = 16'h0004;
    localparam logic [15:0] CNT_FIVE = 16'h0005;
    localparam logic [7:0] UNIT_MAX = 8'h31;
    localparam logic [7:0] DCODE_MIN = 8'h01;
    localparam logic [7:0] DCODE_MAX = 8'h02;
    localparam logic [15:0] STATUS_MAX = 16'h0011;
    localparam logic [7:0] INIT_STAT_MAX = 8'h99;
    localparam logic [3:0] NEG_ONE_DIGIT = 4'hA;
    localparam logic [3:0] MINUS_DIGIT = 4'hF;
    localparam logic [3:0] DIGIT_MAX = 4'h9;

    // ==========================================================
    // receive block slots and memory
    // ==========================================================
    localparam int RX_DEPTH = 4;
    localparam logic [1:0] RX_W0 = 2'd0;
    localparam logic [1:0] RX_W1 = 2'd1;
    localparam logic [1:0] RX_W2 = 2'd2;

    // ascii header codes, permitted writes and reads
    localparam logic [15:0] HDR_W [7] = '{16'h4D42, 16'h5753, 16'h5725, 16'h5757,
                                           16'h5742, 16'h574E, 16'h5756};
    localparam logic [15:0] HDR_R [7] = '{16'h5253, 16'h5225, 16'h5257, 16'h5242,
                                           16'h524E, 16'h5256, 16'h524F};

    // host send block as seen by the block
    typedef struct packed {
        logic [8:0] seq;
        logic [15:0] count;
        logic [15:0] unit_word;
        logic [15:0] header;
        logic [15:0] dcode_word;
        logic [15:0] wdata;
    } send_blk_t;

    // controller reply fields
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] aux;
        logic [15:0] completion;
    } reply_t;

    // link request to the controller unit
    typedef struct packed {
        logic [8:0] seq;
        logic [7:0] unit;
        logic [15:0] header;
        logic [7:0] dcode;
        logic [15:0] wdata;
    } link_req_t;

endpackage
`default_nettype wire

// ### tb/ctrl_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_unit_model
    import seq_map_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // request from the mapper
    input wire logic i_link_req,
    // reply content and pacing
    input wire logic [3:0] i_delay,
    input wire logic [15:0] i_value,
    input wire logic [15:0] i_aux,
    input wire logic [15:0] i_comp,
    // answers
    output logic o_ack,
    output logic o_reply_valid,
    output seq_map_pkg::reply_t o_reply
);
    int cnt;
    logic busy_ff;
    // ==========================================================
    // unit timing
    // ==========================================================
    // accept after i_delay cycles, reply after as many again
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        o_reply_valid <= 1'b0;
        o_reply <= ~o_reply; // stale lines keep moving, never look valid
        if (i_srst)
        begin
            cnt <= 0;
            busy_ff <= 1'b0;
            o_reply <= '0;
        end
        else if (cnt < i_delay && (busy_ff || i_link_req))
            cnt <= cnt + 1;
        else if (!busy_ff && i_link_req && !o_ack)
        begin
            o_ack <= 1'b1;
            busy_ff <= 1'b1;
            cnt <= 0;
        end
        else if (busy_ff)
        begin
            o_reply_valid <= 1'b1;
            o_reply <= '{i_value, i_aux, i_comp};
            busy_ff <= 1'b0;
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_controller_sequence_word_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module test_controller_sequence_word_mapper;
    import seq_map_pkg::*;
    localparam logic [15:0] Z = 16'h0000;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_start = 1'b0;
    send_blk_t i_send = '0;
    logic [1:0] i_rx_addr = 2'h0;
    logic o_busy, o_done, o_error, o_link_req, i_link_ack, i_reply_valid;
    logic [15:0] o_rx_data, o_rx_words, val = Z, aux = Z, cmp = Z;
    link_req_t o_link;
    reply_t i_reply;
    logic [3:0] dly = 4'h0;
    logic [31:0] rng = 32'h0000_0040;
    int n_fail = 0;
    int compares = 0;
    logic [15:0] rxm [3];
    // ==========================================================
    // blocks the host must not send
    // ==========================================================
    send_blk_t bad [10] = '{
        '{SEQ_SP_LIMIT, CNT_THREE, 16'h0005, Z, Z, Z},
        '{SEQ_HEATER, CNT_TWO, 16'h0032, Z, Z, Z},
        '{SEQ_INIT_STAT, CNT_TWO, 16'h001A, Z, Z, Z},
        '{SEQ_GP_WRITE, CNT_FIVE, 16'h0031, HDR_R[0], 16'h0001, 16'h1234},
        '{SEQ_GP_WRITE, CNT_FIVE, Z, HDR_W[6], 16'h0003, 16'h1234},
        '{SEQ_GP_WRITE, CNT_FIVE, Z, HDR_W[2], 16'h0001, 16'h12A4},
        '{SEQ_GP_WRITE, CNT_FOUR, Z, HDR_W[2], 16'h0001, 16'h1234},
        '{SEQ_GP_READ, CNT_FOUR, 16'h0010, HDR_W[1], 16'h0002, Z},
        '{SEQ_GP_READ, CNT_FOUR, 16'h0010, HDR_R[1], Z, Z},
        '{9'h0D4, CNT_TWO, 16'h0010, Z, Z, Z}};

    controller_sequence_word_mapper controller_sequence_word_mapper_inst (
        .i_clk, .i_srst, .i_start, .i_send, .o_busy, .o_done, .o_error,
        .i_rx_addr, .o_rx_data, .o_rx_words, .o_link_req, .o_link,
        .i_link_ack, .i_reply_valid, .i_reply);
    ctrl_unit_model ctrl_unit_model_inst (
        .i_clk, .i_srst, .i_link_req(o_link_req), .i_delay(dly), .i_value(val),
        .i_aux(aux), .i_comp(cmp), .o_ack(i_link_ack),
        .o_reply_valid(i_reply_valid), .o_reply(i_reply));

    // free running bench clock
    initial
    begin
        forever #12.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic bit isbcd(logic [15:0] v);
        for (int i = 0; i < 4; i++)
            if (v[4*i+:4] > 4'h9) return 1'b0;
        return 1'b1;
    endfunction

    // legal unit number, junk in the ignored high byte
    function automatic logic [15:0] ub(int u);
        logic [31:0] r;
        r = rnd();
        return {r[7:0], 4'(u / 10), 4'(u % 10)};
    endfunction

    // reference acceptance of a send block
    function automatic bit ok(send_blk_t s);
        bit hw = 1'b0;
        bit hr = 1'b0;
        bit u;
        bit d;
        for (int i = 0; i < 7; i++)
        begin
            hw |= s.header === HDR_W[i];
            hr |= s.header === HDR_R[i];
        end
        u = isbcd({8'h00, s.unit_word[7:0]}) && s.unit_word[7:0] <= UNIT_MAX;
        d = s.dcode_word[7:0] >= DCODE_MIN && s.dcode_word[7:0] <= DCODE_MAX;
        case (s.seq)
            SEQ_SP_LIMIT, SEQ_HEATER, SEQ_INIT_STAT: return s.count == CNT_TWO && u;
            SEQ_GP_WRITE: return s.count == CNT_FIVE && u && hw && d && isbcd(s.wdata);
            SEQ_GP_READ: return s.count == CNT_FOUR && u && hr && d;
            default: return 1'b0;
        endcase
    endfunction

    task automatic check(logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one command end to end, then the whole receive block read back
    task automatic run(send_blk_t s);
        bit good;
        bit asked;
        int t;
        logic [31:0] r;
        good = ok(s);
        asked = 1'b0;
        t = 0;
        r = rnd();
        @(posedge i_clk);
        i_send <= s;
        i_start <= 1'b1;
        // top digit sometimes carries the minus or -1 marker
        val <= r[16] ? {r[17] ? 4'hF : 4'hA, r[11:0] & 12'h777} : r[15:0] & 16'h7777;
        // junk top digit, the type word must come back with it cleared
        aux <= r[31:16] & (s.seq == SEQ_HEATER ? 16'h0011 : 16'hF777);
        cmp <= r[31:16];
        dly <= {1'b0, r[22:20]};
        @(posedge i_clk);
        i_start <= 1'b0;
        do
        begin
            #1;
            if (o_link_req && !asked)
            begin
                asked = 1'b1;
                check(o_link.seq, s.seq);
                check(o_link.unit, s.unit_word[7:0]);
                if (s.seq >= SEQ_GP_WRITE)
                begin
                    check(o_link.header, s.header);
                    check(o_link.dcode, s.dcode_word[7:0]);
                end
                if (s.seq == SEQ_GP_WRITE) check(o_link.wdata, s.wdata);
            end
            if (!o_done) @(posedge i_clk);
            t++;
        end while (!o_done && t < 80);
        check(o_done, 1'b1);
        check(o_busy, 1'b1);
        check(o_error, !good);
        check(asked, good);
        if (good && s.seq != SEQ_GP_WRITE)
        begin
            rxm[0] = s.seq == SEQ_GP_READ ? CNT_TWO : CNT_THREE;
            rxm[1] = s.seq == SEQ_INIT_STAT ? {8'h00, val[7:0]} : val;
            if (s.seq != SEQ_GP_READ)
                rxm[2] = s.seq == SEQ_INIT_STAT ? {4'h0, aux[11:0]} : aux;
        end
        if (good) check(o_rx_words, s.seq == SEQ_GP_WRITE ? Z : rxm[0]);
        for (int a = 0; a < 3; a++)
        begin
            @(posedge i_clk);
            i_rx_addr <= a[1:0];
            repeat (2) @(posedge i_clk);
            #1;
            check(o_rx_data, rxm[a]);
        end
        check(o_busy, 1'b0);
    endtask

    // main sequence
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        // status reads, unit 00 and 31 first
        for (int k = 0; k < 9; k++)
            run('{SEQ_SP_LIMIT + 9'(k % 3), CNT_TWO, ub(k < 2 ? 31 * k : k * 3), Z, Z, Z});
        for (int k = 0; k < 10; k++)
            run(bad[k]);
        for (int h = 0; h < 7; h++)
            run('{SEQ_GP_WRITE, CNT_FIVE, ub(h * 5), HDR_W[h],
                {8'hEE, 8'h01 + 8'(h % 2)}, {4'(h), 12'h999}});
        for (int h = 0; h < 7; h++)
            run('{SEQ_GP_READ, CNT_FOUR, ub(31 - h), HDR_R[h], {8'h5A, 8'h02 - 8'(h % 2)}, Z});
        run('{SEQ_HEATER, CNT_TWO, ub(17), Z, Z, Z});
        final_report();
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
